/* File: logic/pin_sync.sv */
// Two flip-flop synchroniser for a level arriving from outside the clock domain
`timescale 1ns/1ns
`default_nettype none
module pin_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Level in and out
  input wire logic pinIn,
  output logic pinOut
);
  // State: first stage read only by the second
  typedef struct packed {
    logic stage1;
    logic stage2;
  } sync_t;
  sync_t st;
  sync_t next_st;

  // Shift the level through both stages
  always_comb begin
    next_st.stage1 = pinIn;
    next_st.stage2 = st.stage1;
  end

  // Register the stages
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pinOut = st.stage2;
endmodule
`default_nettype wire

/* File: logic/seq_pkg.sv */
// Package: shared types, register map and timing constants of the start-up sequencer
package seq_pkg;
  // Clock and timing
  localparam int CLK_HZ = 20000000;
  localparam int STEP_TIME_US = 100;            // Ramp step 0.1ms
  localparam int MIN_RISE_US = 250;             // Soft-start disabled below 0.250ms
  localparam int UV_FILTER_US = 70;             // Deglitch filter 70us
  localparam int UV_FILTER_CYC = (UV_FILTER_US * (CLK_HZ / 1000000) > 0) ?
    UV_FILTER_US * (CLK_HZ / 1000000) : 1;
  localparam int MIN_RISE_STEPS = (MIN_RISE_US + STEP_TIME_US - 1) / STEP_TIME_US;
  localparam int TB_TOL_PCT = 10;               // Timebase tolerance, informative only

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DELAY = 8'h04;
  localparam logic [7:0] ADDR_RISE = 8'h08;
  localparam logic [7:0] ADDR_SETPT = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_TARGET = 8'h14;

  // Control field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_PINUV_BIT = 1;
  localparam int CTRL_DEGLITCH_BIT = 2;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam logic [31:0] DELAY_RESET = 32'h0000_0000;
  localparam logic [31:0] RISE_RESET = 32'h0000_0000;
  localparam logic [31:0] SETPT_RESET = 32'h0000_0000;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_INIT = 3'b000,
    ST_WAIT_RUN = 3'b001,
    ST_DELAY = 3'b010,
    ST_RAMP = 3'b011,
    ST_DONE = 3'b100
  } seq_state_t;

  // Configuration passed to the sequencer
  typedef struct packed {
    logic enable;
    logic pinUvMode;
    logic deglitchSel;
    logic [15:0] delayTicks;
    logic [15:0] riseSteps;
    logic [15:0] setpoint;
  } seq_cfg_t;

  // Status returned from the sequencer
  typedef struct packed {
    seq_state_t state;
    logic runHold;
    logic dcmForce;
    logic rampDone;
    logic uvPinRelease;
    logic [15:0] target;
  } seq_stat_t;
endpackage

/* File: logic/startup_sequencer.sv */
// Start-up sequencer: run line hold, turn-on delay, soft-start ramp, UV pin
// Notes on behaviour
// R1: Hold run low until init and input good
// R2: Shared run line released only when all ready
// R3: Count turn-on delay after run release
// R4: Time all delays from shared timebase clock; the UV deglitch filter counts clk cycles instead
// R5: Step target from zero up to setpoint
// R6: Rise below quarter millisecond skips the ramp
// R7: Steps equal rise time over 0.1ms
// R8: Force discontinuous mode throughout the ramp
// R9: Pin may release above undervoltage limit
// R10: Config bit selects deglitched over raw compare
// R11: Deglitched compare passes a 70us filter
// R12: Software keeps rise times under 100ms
// R13: Phases get identical timing parameters
// R14: System may chain run to other's pin
// R15: Flag ramp done once target equals setpoint
`timescale 1ns/1ns
`default_nettype none
module startup_sequencer
#(
  parameter int UV_FILTER = seq_pkg::UV_FILTER_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Wishbone slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatIn,
  output logic [31:0] wbDatOut,
  output logic wbAck,
  // Device status inputs
  input wire logic initDone,
  input wire logic inputAboveOn,
  input wire logic outputAboveUv,
  // Shared run line, open drain
  input wire logic runIn,
  output logic runOut,
  output logic runOe_b,
  // Shared timebase clock, sampled
  input wire logic timebaseClk,
  // General purpose pin, open drain
  output logic gpioOut,
  output logic gpioOe_b,
  // Modulator control
  output logic dcmForce,
  output logic [15:0] voltTarget,
  output logic rampDone
);
  import seq_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic runSync;      // Run line level
  logic tbSync;       // Timebase level
  logic uvRawSync;    // Output above UV limit, raw
  logic initSync;     // Initialization finished
  logic vinSync;      // Input above turn-on threshold
  logic uvFilt;       // Deglitched UV compare

  pin_sync u_run (.clk(clk), .rst_b(rst_b), .pinIn(runIn), .pinOut(runSync));
  pin_sync u_tb (.clk(clk), .rst_b(rst_b), .pinIn(timebaseClk), .pinOut(tbSync));
  pin_sync u_uv (.clk(clk), .rst_b(rst_b), .pinIn(outputAboveUv), .pinOut(uvRawSync));
  pin_sync u_ini (.clk(clk), .rst_b(rst_b), .pinIn(initDone), .pinOut(initSync));
  pin_sync u_vin (.clk(clk), .rst_b(rst_b), .pinIn(inputAboveOn), .pinOut(vinSync));

  // Filter the synchronised compare for the deglitched pin release mode; the raw mode bypasses it
  uv_deglitch #(.FILTER_CYC(UV_FILTER)) u_flt ( // R11
    .clk(clk), .rst_b(rst_b), .rawIn(uvRawSync), .filtOut(uvFilt));

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    seq_state_t state;
    seq_cfg_t cfg;
    logic tbPrev;              // Previous timebase level for edge detect
    logic [15:0] tickCnt;      // Timebase ticks counted in the current phase
    logic [15:0] stepIdx;      // Ramp step number
    logic [15:0] target;       // Digital voltage target
    logic runHold;             // Drive run low
    logic dcm;                 // Discontinuous mode forced
    logic done;                // Ramp complete
    logic gpioRel;             // Pin released
    logic [31:0] rdata;
    logic ack;
  } top_t;
  top_t st;
  top_t next_st;

  // Target for a step: setpoint * idx / steps, avoids accumulating error
  function automatic logic [15:0] stepTarget(input logic [15:0] sp,
                                             input logic [15:0] idx,
                                             input logic [15:0] steps);
    logic [31:0] prod;
    prod = 32'(sp) * 32'(idx);
    if (steps == 16'h0000) begin
      stepTarget = sp;
    end else begin
      stepTarget = 16'(prod / 32'(steps));
    end
  endfunction

  // Register read mux
  function automatic logic [31:0] readReg(input top_t s, input logic [7:0] adr);
    case (adr)
      ADDR_CTRL: readReg = {29'h0, s.cfg.deglitchSel, s.cfg.pinUvMode, s.cfg.enable};
      ADDR_DELAY: readReg = {16'h0, s.cfg.delayTicks};
      ADDR_RISE: readReg = {16'h0, s.cfg.riseSteps};
      ADDR_SETPT: readReg = {16'h0, s.cfg.setpoint};
      ADDR_STATUS: readReg = {25'h0, s.gpioRel, s.done, s.dcm, s.runHold, s.state};
      ADDR_TARGET: readReg = {16'h0, s.target};
      default: readReg = 32'h0000_0000;
    endcase
  endfunction

  logic tbTick;  // One-cycle enable at each rising timebase edge
  assign tbTick = tbSync && !st.tbPrev; // R4

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    next_st = st;
    next_st.tbPrev = tbSync;
    next_st.ack = 1'b0;

    // Bus slave: one-cycle ack, unmapped reads give zero
    if (wbCyc && wbStb && !st.ack) begin
      next_st.ack = 1'b1;
      next_st.rdata = readReg(st, wbAdr);
      if (wbWe && wbSel[0]) begin
        case (wbAdr)
          ADDR_CTRL: begin
            next_st.cfg.enable = wbDatIn[CTRL_ENABLE_BIT];
            next_st.cfg.pinUvMode = wbDatIn[CTRL_PINUV_BIT];
            next_st.cfg.deglitchSel = wbDatIn[CTRL_DEGLITCH_BIT];
          end
          ADDR_DELAY: next_st.cfg.delayTicks[7:0] = wbDatIn[7:0];
          ADDR_RISE: next_st.cfg.riseSteps[7:0] = wbDatIn[7:0];
          ADDR_SETPT: next_st.cfg.setpoint[7:0] = wbDatIn[7:0];
          default: begin
          end
        endcase
      end
      if (wbWe && wbSel[1]) begin
        case (wbAdr)
          ADDR_DELAY: next_st.cfg.delayTicks[15:8] = wbDatIn[15:8];
          ADDR_RISE: next_st.cfg.riseSteps[15:8] = wbDatIn[15:8];
          ADDR_SETPT: next_st.cfg.setpoint[15:8] = wbDatIn[15:8];
          default: begin
          end
        endcase
      end
    end

    // Sequencer
    case (st.state)
      ST_INIT: begin
        next_st.runHold = 1'b1;
        next_st.target = '0;
        next_st.dcm = 1'b0;
        next_st.done = 1'b0;
        if (initSync && vinSync && st.cfg.enable) begin
          next_st.runHold = 1'b0; // R1
          next_st.state = ST_WAIT_RUN;
        end
      end
      ST_WAIT_RUN: begin
        // Others may still hold the line; start only when it reads high
        if (!(initSync && vinSync && st.cfg.enable)) begin
          next_st.runHold = 1'b1;
          next_st.state = ST_INIT;
        end else if (runSync) begin // R2
          next_st.tickCnt = '0;
          next_st.state = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (!runSync) begin
          next_st.state = ST_WAIT_RUN;
        end else if (st.tickCnt >= st.cfg.delayTicks) begin // R3
          next_st.tickCnt = '0;
          next_st.stepIdx = '0;
          if (st.cfg.riseSteps < 16'(MIN_RISE_STEPS)) begin // R6
            next_st.target = st.cfg.setpoint;
            next_st.done = 1'b1;
            next_st.state = ST_DONE;
          end else begin
            next_st.target = '0; // R5
            next_st.dcm = 1'b1; // R8
            next_st.state = ST_RAMP;
          end
        end else if (tbTick) begin
          next_st.tickCnt = st.tickCnt + 16'h0001;
        end
      end
      ST_RAMP: begin
        if (!runSync) begin
          next_st.dcm = 1'b0;
          next_st.state = ST_WAIT_RUN;
        end else if (tbTick) begin
          // One timebase tick is one 0.1ms step
          next_st.stepIdx = st.stepIdx + 16'h0001; // R7
          next_st.target = stepTarget(st.cfg.setpoint, st.stepIdx + 16'h0001,
                                      st.cfg.riseSteps); // R5
          if (st.stepIdx + 16'h0001 >= st.cfg.riseSteps) begin
            next_st.target = st.cfg.setpoint;
            next_st.dcm = 1'b0;
            next_st.done = 1'b1; // R15
            next_st.state = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        if (!runSync) begin
          next_st.done = 1'b0;
          next_st.target = '0;
          next_st.state = ST_WAIT_RUN;
        end
      end
      default: next_st.state = ST_INIT;
    endcase

    // Losing readiness in any later state pulls the line low again
    if (!(initSync && vinSync && st.cfg.enable) && st.state != ST_INIT) begin // R1
      next_st.runHold = 1'b1;
      next_st.dcm = 1'b0;
      next_st.done = 1'b0;
      next_st.target = '0;
      next_st.state = ST_INIT;
    end

    // Pin release above UV limit, raw or deglitched compare
    next_st.gpioRel = st.cfg.pinUvMode &&
                      (st.cfg.deglitchSel ? uvFilt : uvRawSync); // R9 R10
  end

  // Register all state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
      st.state <= ST_INIT;
      st.runHold <= 1'b1;
      st.cfg.enable <= CTRL_RESET[CTRL_ENABLE_BIT];
      st.cfg.delayTicks <= DELAY_RESET[15:0];
      st.cfg.riseSteps <= RISE_RESET[15:0];
      st.cfg.setpoint <= SETPT_RESET[15:0];
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs from flip-flops; run and pin drive levels tied low
  assign wbDatOut = st.rdata;
  assign wbAck = st.ack;
  assign runOut = 1'b0;
  assign runOe_b = !st.runHold;
  assign gpioOut = 1'b0;
  assign gpioOe_b = st.gpioRel;
  assign dcmForce = st.dcm;
  assign voltTarget = st.target;
  assign rampDone = st.done;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_rampStart;
    st.state == ST_DELAY ##1 st.state == ST_RAMP;
  endsequence

  property p_runHeld;
    @(posedge clk) disable iff (!rst_b)
      !(initSync && vinSync) |-> ##1 !runOe_b;
  endproperty
  a_runHeld: assert property (p_runHeld) else $error("run released early"); // R1

  property p_delayNeedsRun;
    @(posedge clk) disable iff (!rst_b)
      (st.state == ST_WAIT_RUN && !runSync) |=> st.state != ST_DELAY;
  endproperty
  a_delayNeedsRun: assert property (p_delayNeedsRun) else $error("delay without run"); // R2

  property p_delayCount;
    @(posedge clk) disable iff (!rst_b)
      s_rampStart |-> $past(st.tickCnt, 1) >= st.cfg.delayTicks;
  endproperty
  a_delayCount: assert property (p_delayCount) else $error("delay cut short"); // R3

  property p_tickOnEdge;
    @(posedge clk) disable iff (!rst_b)
      ($past(st.state) == ST_RAMP && st.state == ST_RAMP && $changed(st.stepIdx)) |->
        $past(tbTick);
  endproperty
  a_tickOnEdge: assert property (p_tickOnEdge) else $error("step off timebase"); // R4

  property p_rampFromZero;
    @(posedge clk) disable iff (!rst_b)
      s_rampStart |-> voltTarget == 16'h0000;
  endproperty
  a_rampFromZero: assert property (p_rampFromZero) else $error("ramp not from zero"); // R5

  property p_shortRise;
    @(posedge clk) disable iff (!rst_b)
      (st.state == ST_DELAY && next_st.state == ST_DONE) |=>
        (!dcmForce && voltTarget == st.cfg.setpoint);
  endproperty
  a_shortRise: assert property (p_shortRise) else $error("short rise not skipped"); // R6

  property p_stepCount;
    @(posedge clk) disable iff (!rst_b)
      ($past(st.state) == ST_RAMP && st.state == ST_DONE) |->
        st.stepIdx == st.cfg.riseSteps;
  endproperty
  a_stepCount: assert property (p_stepCount) else $error("wrong step count"); // R7

  property p_dcmInRamp;
    @(posedge clk) disable iff (!rst_b)
      st.state == ST_RAMP |-> dcmForce;
  endproperty
  a_dcmInRamp: assert property (p_dcmInRamp) else $error("ramp without dcm"); // R8

  property p_pinFollow;
    @(posedge clk) disable iff (!rst_b)
      (st.cfg.pinUvMode && !st.cfg.deglitchSel && $stable(st.cfg) && uvRawSync) |=> gpioOe_b;
  endproperty
  a_pinFollow: assert property (p_pinFollow) else $error("pin not released"); // R9 R10

  property p_doneTarget;
    @(posedge clk) disable iff (!rst_b)
      rampDone |-> voltTarget == st.cfg.setpoint;
  endproperty
  a_doneTarget: assert property (p_doneTarget) else $error("done off setpoint"); // R15
endmodule
`default_nettype wire

/* File: logic/uv_deglitch.sv */
// Deglitch filter: output follows input only after it has held steady
`timescale 1ns/1ns
`default_nettype none
module uv_deglitch #(
  parameter int FILTER_CYC = seq_pkg::UV_FILTER_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Raw and filtered levels
  input wire logic rawIn,
  output logic filtOut
);
  // State: stable count and accepted level
  typedef struct packed {
    logic [15:0] count;
    logic level;
  } flt_t;
  flt_t st;
  flt_t next_st;

  // Restart count on every change; accept after a full quiet period
  always_comb begin
    next_st = st;
    if (rawIn == st.level) begin
      next_st.count = '0;
    end else if (st.count >= 16'(FILTER_CYC - 1)) begin
      next_st.level = rawIn;
      next_st.count = '0;
    end else begin
      next_st.count = st.count + 16'h0001;
    end
  end

  // Register the state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign filtOut = st.level;
endmodule
`default_nettype wire

/* File: verification/peer_ctrl.sv */
// Peer controller model: shares the run line and drives the common timebase
`timescale 1ns/1ns
`default_nettype none
module peer_ctrl #(
  parameter int HALF_NS = 200
) (
  // Readiness of this peer
  input wire logic peerReady,
  // Shared lines, run enable is active low
  output logic peerOe_b,
  output logic timebaseClk
);
  ////////////////////////////////////////////////////////////////////////////
  // Free-running timebase; the odd start offset keeps its edges clear of clk edges
  initial begin
    timebaseClk = 1'b0;
    peerOe_b = 1'b0;
    #137;
    forever #HALF_NS timebaseClk = ~timebaseClk;
  end
  // Run held low until ready; moves on falling edges, away from the ticks
  always @(negedge timebaseClk) begin
    peerOe_b <= peerReady;
  end
endmodule
`default_nettype wire

/* File: verification/startup_delay_soft_start_sequencer_tb.sv */
// Testbench for the start-up sequencer with one peer on the run line
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checksDone++; if ((g) !== (e)) begin errorCnt++; \
  $display("[FAIL] t=%0t got %0h exp %0h", $time, (g), (e)); end end
module startup_delay_soft_start_sequencer_tb;
  import seq_pkg::*;
  localparam int UVF = 10;
  logic clk, rst_b, wbCyc, wbStb, wbWe, wbAck, initDone, inputAboveOn, outputAboveUv;
  logic [7:0] wbAdr;
  logic [3:0] wbSel;
  logic [31:0] wbDatIn, wbDatOut, rd;
  logic runOut, runOe_b, timebaseClk, gpioOut, gpioOe_b, dcmForce, rampDone;
  logic peerReady, peerOe_b, runWire, tbPrev, chainRun;
  logic [15:0] voltTarget;
  int errorCnt, checksDone, cycles;
  // Pulled-up run line, low while either party drives it
  assign runWire = (runOe_b | runOut) & peerOe_b;
  // Run line of a second controller chained to this pin, pulled up
  assign chainRun = gpioOe_b | gpioOut;
  ////////////////////////////////////////////////////////////////////////////
  startup_sequencer #(.UV_FILTER(UVF)) dut (.clk(clk), .rst_b(rst_b), .wbCyc(wbCyc),
    .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatIn(wbDatIn),
    .wbDatOut(wbDatOut), .wbAck(wbAck), .initDone(initDone), .inputAboveOn(inputAboveOn),
    .outputAboveUv(outputAboveUv), .runIn(runWire), .runOut(runOut), .runOe_b(runOe_b),
    .timebaseClk(timebaseClk), .gpioOut(gpioOut), .gpioOe_b(gpioOe_b),
    .dcmForce(dcmForce), .voltTarget(voltTarget), .rampDone(rampDone));
  peer_ctrl peer (.peerReady(peerReady), .peerOe_b(peerOe_b), .timebaseClk(timebaseClk));
  ////////////////////////////////////////////////////////////////////////////
  // Clock, timebase edge history and hang guard
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    tbPrev <= timebaseClk;
    cycles++;
    if (cycles == 30000) begin
      errorCnt++;
      closeOut();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Classic single Wishbone cycle; read data lands in rd
  // Waits for ack however long it takes; only the hang guard ends a stuck cycle
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDatIn <= d;
    do begin
      @(posedge clk);
    end while (wbAck !== 1'b1);
    rd = wbDatOut;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    wb(1'b0, ADDR_CTRL, 32'h0);
    `CHK(rd, CTRL_RESET)
    wb(1'b0, ADDR_DELAY, 32'h0);
    `CHK(rd, DELAY_RESET)
    wb(1'b0, ADDR_RISE, 32'h0);
    `CHK(rd, RISE_RESET)
    wb(1'b0, 8'h1C, 32'h0);
    `CHK(rd, 32'h0)
    wb(1'b1, ADDR_DELAY, 32'h3);
    wb(1'b1, ADDR_RISE, 32'h4);
    wb(1'b1, ADDR_SETPT, 32'h100);
    wb(1'b0, ADDR_SETPT, 32'h0);
    `CHK(rd, 32'h100)
    $display("regs test done");
  endtask
  // Run release waits for own readiness, then for the peer
  task automatic t_hold();
    tick(50);
    `CHK(runOe_b, 1'b0)
    initDone <= 1'b1;
    inputAboveOn <= 1'b0;
    tick(50);
    `CHK(runOe_b, 1'b0)
    inputAboveOn <= 1'b1;
    tick(8);
    `CHK(runOe_b, 1'b1)
    tick(60);
    `CHK(runWire, 1'b0)
    `CHK(dcmForce, 1'b0)
    `CHK(voltTarget, 16'h0)
    $display("hold test done");
  endtask
  // Delay of 3 ticks, then a 4 step ramp to 0x100
  task automatic t_ramp();
    int n;
    int k;
    peerReady <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (runWire !== 1'b1 && n < 100);
    k = 0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (timebaseClk && !tbPrev) k++;
    end while (dcmForce !== 1'b1 && n < 200);
    `CHK(k, 3)
    tick(1);
    `CHK(voltTarget, 16'h0)
    for (int s = 1; s <= 4; s++) begin
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (!(timebaseClk && !tbPrev) && n < 20);
      tick(6);
      `CHK(voltTarget, 16'(64 * s))
      `CHK(dcmForce, 1'(s < 4))
    end
    `CHK(rampDone, 1'b1)
    wb(1'b0, ADDR_TARGET, 32'h0);
    `CHK(rd, 32'h100)
    $display("ramp test done");
  endtask
  // Run dropped after the ramp is done, then a rise too short for soft-start
  task automatic t_short();
    logic sawDcm;
    int n;
    peerReady <= 1'b0;
    tick(30);
    `CHK(voltTarget, 16'h0)
    `CHK(rampDone, 1'b0)
    wb(1'b1, ADDR_RISE, 32'h2);
    wb(1'b1, ADDR_DELAY, 32'h1);
    peerReady <= 1'b1;
    sawDcm = 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (dcmForce === 1'b1) sawDcm = 1'b1;
    end while (rampDone !== 1'b1 && n < 300);
    `CHK(sawDcm, 1'b0)
    `CHK(voltTarget, 16'h100)
    // Input dropping after start must pull the run line low again
    inputAboveOn <= 1'b0;
    tick(6);
    `CHK(runOe_b, 1'b0)
    `CHK(rampDone, 1'b0)
    $display("short rise test done");
  endtask
  // Pin release on raw and on filtered compare, glitch rejected
  task automatic t_gpio();
    wb(1'b1, ADDR_CTRL, 32'h3);
    outputAboveUv <= 1'b1;
    tick(6);
    `CHK(gpioOe_b, 1'b1)
    `CHK(chainRun, 1'b1)
    outputAboveUv <= 1'b0;
    tick(6);
    `CHK(gpioOe_b, 1'b0)
    `CHK(chainRun, 1'b0)
    wb(1'b1, ADDR_CTRL, 32'h7);
    outputAboveUv <= 1'b1;
    tick(5);
    outputAboveUv <= 1'b0;
    tick(20);
    `CHK(gpioOe_b, 1'b0)
    outputAboveUv <= 1'b1;
    tick(8);
    `CHK(gpioOe_b, 1'b0)
    tick(20);
    `CHK(gpioOe_b, 1'b1)
    $display("gpio test done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic closeOut();
    $display("checks %0d mismatches %0d", checksDone, errorCnt);
    if (errorCnt == 0 && checksDone > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    rst_b = 1'b0;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = 8'h00;
    wbSel = 4'h3;
    wbDatIn = 32'h0;
    initDone = 1'b0;
    inputAboveOn = 1'b1;
    outputAboveUv = 1'b0;
    peerReady = 1'b0;
    tick(5);
    rst_b <= 1'b1;
    t_regs();
    t_hold();
    t_ramp();
    t_short();
    t_gpio();
    closeOut();
  end
endmodule
`default_nettype wire
